//--- rtl/mctu_top.v
// multi channel timer unit: four pwm subsystems with flags and requests
`timescale 1ns/10ps
`include "mctu_defs.vh"
module mctu_top (
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire [3:0] low_power_i,
  input wire [3:0] wide_mode_i,
  input wire [7:0] counter_go_bit_i,
  input wire [7:0] output_default_level_bit_i,
  input wire [31:0] prescale_match_field_i,
  input wire [3:0] cnt_wr_i,
  input wire [63:0] cnt_wdata_i,
  input wire [3:0] per_wr_i,
  input wire [3:0] duty_wr_i,
  input wire [63:0] cmp_wdata_i,
  input wire [15:0] irq_en_i,
  input wire [15:0] flag_clr_i,
  input wire [7:0] timer_io_pin_i,
  output reg [7:0] timer_io_pin_o,
  output reg [7:0] timer_io_pin_oe_o,
  output reg [63:0] subsystem_counter_o,
  output reg [63:0] period_compare_register_o,
  output reg [63:0] duty_compare_register_o,
  output reg [15:0] match_flag_o,
  output reg [3:0] irq_o,
  output reg [7:0] pin_in_o
);
  reg [7:0] pin_s1_q; // first synchroniser stage
  reg [7:0] pin_s2_q; // second synchroniser stage
  reg [63:0] per_sh_q; // software-visible period
  reg [63:0] duty_sh_q; // software-visible duty
  reg [63:0] per_act_q; // active period
  reg [63:0] duty_act_q; // active duty
  reg [3:0] pend_q; // buffered update waiting
  reg [15:0] flag_q; // sticky match flags
  reg [7:0] act16_q; // wide-mode output state per subsystem (bit 2s)
  wire [63:0] cnt_w;
  wire [7:0] per_eq_w;
  wire [7:0] duty_eq_w;
  wire [7:0] wrap_w;
  wire [7:0] z_w;
  wire [7:0] act_w;
  wire [3:0] tick_w;
  wire [7:0] run_w;
  wire [3:0] any_w;
  wire [15:0] ev_w;
  genvar g;

  // pins are sampled through two flops; capture mode is not built, pins only observed
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else if (ce_i) begin
      pin_s1_q <= timer_io_pin_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  generate
    for (g = 0; g < 4; g = g + 1) begin : sub
      wire lp;
      wire wide;
      wire go_lo;
      wire go_hi;
      wire stop_lo;
      wire wide_per;
      wire wide_inc;
      wire [15:0] c16;
      wire [15:0] d16;
      wire [15:0] p16;
      assign lp = low_power_i[g];
      assign wide = wide_mode_i[g];
      assign go_lo = counter_go_bit_i[2*g] & ~lp;
      assign go_hi = counter_go_bit_i[2*g+1] & ~lp & ~wide;
      assign run_w[2*g] = go_lo;
      assign run_w[2*g+1] = wide ? go_lo : go_hi;
      assign any_w[g] = go_lo | go_hi;
      assign c16 = cnt_w[16*g+15:16*g];
      assign d16 = duty_act_q[16*g+15:16*g];
      assign p16 = per_act_q[16*g+15:16*g];
      assign wide_per = per_eq_w[2*g] & per_eq_w[2*g+1];
      assign wide_inc = go_lo & tick_w[g];
      assign stop_lo = ~any_w[g];

      mctu_prescaler u_ps (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i & ~lp),
        .any_run_i(any_w[g]),
        .match_i(prescale_match_field_i[8*g+7:8*g]),
        .tick_o(tick_w[g])
      );
      mctu_pwm_lane u_lo (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i & ~lp),
        .run_i(run_w[2*g]),
        .tick_i(tick_w[g]),
        .carry_in_i(1'b1),
        .wide_i(wide),
        .load_i(cnt_wr_i[g] & stop_lo),
        .load_val_i(cnt_wdata_i[16*g+7:16*g]),
        .per_i(per_act_q[16*g+7:16*g]),
        .duty_i(duty_act_q[16*g+7:16*g]),
        .hi_per_eq_i(per_eq_w[2*g+1]),
        .hi_duty_eq_i(duty_eq_w[2*g+1]),
        .cnt_o(cnt_w[16*g+7:16*g]),
        .per_eq_o(per_eq_w[2*g]),
        .duty_eq_o(duty_eq_w[2*g]),
        .wrap_o(wrap_w[2*g]),
        .step01_o(z_w[2*g]),
        .active_o(act_w[2*g])
      );
      mctu_pwm_lane u_hi (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i & ~lp),
        .run_i(run_w[2*g+1]),
        .tick_i(tick_w[g]),
        .carry_in_i(wrap_w[2*g]),
        .wide_i(wide),
        .load_i(cnt_wr_i[g] & stop_lo),
        .load_val_i(cnt_wdata_i[16*g+15:16*g+8]),
        .per_i(per_act_q[16*g+15:16*g+8]),
        .duty_i(duty_act_q[16*g+15:16*g+8]),
        .hi_per_eq_i(per_eq_w[2*g]),
        .hi_duty_eq_i(duty_eq_w[2*g]),
        .cnt_o(cnt_w[16*g+15:16*g+8]),
        .per_eq_o(per_eq_w[2*g+1]),
        .duty_eq_o(duty_eq_w[2*g+1]),
        .wrap_o(wrap_w[2*g+1]),
        .step01_o(z_w[2*g+1]),
        .active_o(act_w[2*g+1])
      );

      // match events per byte in dual mode, whole word in wide mode
      assign ev_w[4*g+0] = wide ? (wide_inc & (c16 == d16)) : (run_w[2*g] & tick_w[g] & duty_eq_w[2*g]);
      assign ev_w[4*g+1] = wide ? (wide_inc & wide_per) : (run_w[2*g] & tick_w[g] & per_eq_w[2*g]);
      assign ev_w[4*g+2] = ~wide & run_w[2*g+1] & tick_w[g] & duty_eq_w[2*g+1];
      assign ev_w[4*g+3] = ~wide & run_w[2*g+1] & tick_w[g] & per_eq_w[2*g+1];

      // wide-mode output state from the full 16-bit compare
      always @(posedge clk_i) begin
        if (sys_rst_i) begin
          act16_q[2*g] <= 1'b0;
        end else if (ce_i & ~lp) begin
          if (~go_lo) begin
            act16_q[2*g] <= 1'b0;
          end else if (wide_inc) begin
            if (c16 == 16'h0000 && d16 != 16'h0000) begin
              act16_q[2*g] <= 1'b1;
            end else if (c16 == d16 && c16 != p16) begin
              act16_q[2*g] <= 1'b0;
            end else if (d16 > p16 && d16 != 16'h0000) begin
              act16_q[2*g] <= 1'b1;
            end
          end
        end
      end
      always @(posedge clk_i) begin
        if (sys_rst_i) begin
          act16_q[2*g+1] <= 1'b0;
        end else if (ce_i) begin
          act16_q[2*g+1] <= 1'b0;
        end
      end

      // double-buffered compares: shadow written on any strobe outside low power, active loaded at period match or stop
      always @(posedge clk_i) begin
        if (sys_rst_i) begin
          per_sh_q[16*g+15:16*g] <= `MCTU_CMP_RST;
          duty_sh_q[16*g+15:16*g] <= `MCTU_CMP_RST;
          per_act_q[16*g+15:16*g] <= `MCTU_CMP_RST;
          duty_act_q[16*g+15:16*g] <= `MCTU_CMP_RST;
          pend_q[g] <= 1'b0;
        end else if (ce_i & ~lp) begin
          if (per_wr_i[g]) begin
            per_sh_q[16*g+15:16*g] <= cmp_wdata_i[16*g+15:16*g];
          end
          if (duty_wr_i[g]) begin
            duty_sh_q[16*g+15:16*g] <= cmp_wdata_i[16*g+15:16*g];
          end
          if (per_wr_i[g] | duty_wr_i[g]) begin
            pend_q[g] <= 1'b1;
          end else if (pend_q[g] & (stop_lo | ev_w[4*g+1] | ev_w[4*g+3])) begin
            per_act_q[16*g+15:16*g] <= per_sh_q[16*g+15:16*g];
            duty_act_q[16*g+15:16*g] <= duty_sh_q[16*g+15:16*g];
            pend_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // sticky flags: a new event wins over a same-cycle clear; clears blocked in low power
  always @(posedge clk_i) begin : flags
    integer i;
    if (sys_rst_i) begin
      flag_q <= 16'h0000;
    end else if (ce_i) begin
      for (i = 0; i < 16; i = i + 1) begin
        if (ev_w[i]) begin
          flag_q[i] <= 1'b1;
        end else if (flag_clr_i[i] & ~low_power_i[i/4]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // registered outputs: pins, enables, requests and visible state
  always @(posedge clk_i) begin : outs
    integer s;
    if (sys_rst_i) begin
      timer_io_pin_o <= 8'h00;
      timer_io_pin_oe_o <= 8'h00;
      irq_o <= 4'h0;
      subsystem_counter_o <= 64'h0;
      period_compare_register_o <= 64'h0;
      duty_compare_register_o <= 64'h0;
      match_flag_o <= 16'h0000;
      pin_in_o <= 8'h00;
    end else if (ce_i) begin
      for (s = 0; s < 4; s = s + 1) begin
        if (wide_mode_i[s]) begin
          timer_io_pin_o[2*s] <= output_default_level_bit_i[2*s] ^ act16_q[2*s];
          timer_io_pin_o[2*s+1] <= output_default_level_bit_i[2*s+1] ^ act16_q[2*s];
        end else begin
          timer_io_pin_o[2*s] <= output_default_level_bit_i[2*s] ^ act_w[2*s];
          timer_io_pin_o[2*s+1] <= output_default_level_bit_i[2*s+1] ^ act_w[2*s+1];
        end
        irq_o[s] <= |(flag_q[4*s+3 -: 4] & irq_en_i[4*s+3 -: 4]);
      end
      timer_io_pin_oe_o <= 8'hff;
      subsystem_counter_o <= cnt_w;
      period_compare_register_o <= per_sh_q;
      duty_compare_register_o <= duty_sh_q;
      match_flag_o <= flag_q;
      pin_in_o <= pin_s2_q;
    end
  end
endmodule

//--- shared/mctu_defs.vh
// constants of the multi channel timer unit
// What this block does
// - four subsystems: prescaler, counter, two compares
// - eight pins, pwm output only; inputs observed, no capture
// - sixteen flags, enables, one request per subsystem
// - low-power state stops all subsystem clocks
// - dual mode: two 8-bit counters, own go bits
// - prescaler runs while any counter runs
// - period match clears; 00h-01h step toggles output
// - duty match returns output to default next step
// - duty above period gives 100% duty
// - zero duty keeps output at default level
// - period and duty double buffered while running
// - reads return last written period and duty
// - counter writes only while both go bits clear (only the lower go bit in 16-bit mode)
// - preset counts from value, first 00h-01h toggles
// - preset above period rolls over at FFh
// - stop: default level, hold count, prescaler reset once both counters of the subsystem stop
// - 16-bit mode: concatenated counter, lower go bit
// - 16-bit mode: both pins same waveform, own polarity
// - flags: duty and period matches per byte in dual mode, whole word in 16-bit mode
`ifndef MCTU_DEFS_VH
`define MCTU_DEFS_VH
`define MCTU_NSUB 4
`define MCTU_PS_W 8
`define MCTU_CNT_W 16
`define MCTU_BYTE_W 8
`define MCTU_CNT_RST 16'h0000
`define MCTU_PS_RST 8'h00
`define MCTU_CMP_RST 16'h0000
`define MCTU_FLG_LDUTY 0
`define MCTU_FLG_LPER 1
`define MCTU_FLG_HDUTY 2
`define MCTU_FLG_HPER 3
`endif

//--- rtl/mctu_pwm_lane.v
// one 8-bit pwm lane: counter byte, compare, output level
`timescale 1ns/10ps
`include "mctu_defs.vh"
module mctu_pwm_lane (
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire run_i,
  input wire tick_i,
  input wire carry_in_i,
  input wire wide_i,
  input wire load_i,
  input wire [7:0] load_val_i,
  input wire [7:0] per_i,
  input wire [7:0] duty_i,
  input wire hi_per_eq_i,
  input wire hi_duty_eq_i,
  output wire [7:0] cnt_o,
  output wire per_eq_o,
  output wire duty_eq_o,
  output wire wrap_o,
  output wire step01_o,
  output wire active_o
);
  reg [7:0] cnt_q; // counter byte, kept across stop
  reg act_q; // output in its opposite level
  wire inc; // this byte advances now
  wire clr; // period reached, clear instead of increment
  assign per_eq_o = (cnt_q == per_i);
  assign duty_eq_o = (cnt_q == duty_i);
  // in wide mode the high byte only moves on a low byte carry or a wide clear
  assign inc = run_i & tick_i & (~wide_i | carry_in_i);
  assign clr = wide_i ? (per_eq_o & hi_per_eq_i) : per_eq_o;
  assign wrap_o = (cnt_q == 8'hff) | clr;
  assign step01_o = (cnt_q == 8'h00);
  assign cnt_o = cnt_q;
  assign active_o = act_q;
  // counter byte: clear on period match, roll over at ffh otherwise
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= 8'h00;
    end else if (ce_i) begin
      if (load_i) begin
        cnt_q <= load_val_i;
      end else if (inc) begin
        if (clr) begin
          cnt_q <= 8'h00;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
  // output level state; only used when not wide
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      act_q <= 1'b0;
    end else if (ce_i) begin
      if (~run_i) begin
        act_q <= 1'b0;
      end else if (inc & ~wide_i) begin
        if (cnt_q == 8'h00 && duty_i != 8'h00) begin
          act_q <= 1'b1;
        end else if (duty_eq_o & ~per_eq_o) begin
          act_q <= 1'b0;
        end else if (duty_i > per_i && duty_i != 8'h00) begin
          act_q <= 1'b1;
        end
      end
    end
  end
endmodule

//--- rtl/mctu_prescaler.v
// 8-bit prescaler that issues one count tick per match
`timescale 1ns/10ps
`include "mctu_defs.vh"
module mctu_prescaler (
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire any_run_i,
  input wire [7:0] match_i,
  output wire tick_o
);
  reg [7:0] ps_q; // prescale count
  assign tick_o = any_run_i & (ps_q == match_i);
  // counts zero to the match field then restarts; cleared when nothing runs
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ps_q <= `MCTU_PS_RST;
    end else if (ce_i) begin
      if (~any_run_i) begin
        ps_q <= `MCTU_PS_RST;
      end else if (tick_o) begin
        ps_q <= `MCTU_PS_RST;
      end else begin
        ps_q <= ps_q + 8'h01;
      end
    end
  end
endmodule

//--- dv/mctu_pin_load.sv
// external load on the timer pins, with a pull-up on each pin
`timescale 1ns/10ps
module mctu_pin_load (
  input wire [7:0] pin_o_i,
  input wire [7:0] pin_oe_i,
  output wire [7:0] pin_level_o
);
  // a released pin floats up, so an undriven pin never reads as a stale level
  assign pin_level_o = (pin_o_i & pin_oe_i) | ~pin_oe_i;
endmodule

//--- dv/mctu_assertions.sv
// concurrent checks on the ports of the timer unit
`timescale 1ns/10ps
module mctu_assertions (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [3:0] low_power_i,
  input wire [7:0] counter_go_bit_i,
  input wire [7:0] output_default_level_bit_i,
  input wire [31:0] prescale_match_field_i,
  input wire [3:0] cnt_wr_i,
  input wire [3:0] per_wr_i,
  input wire [63:0] cmp_wdata_i,
  input wire [15:0] irq_en_i,
  input wire [15:0] flag_clr_i,
  input wire [7:0] timer_io_pin_o,
  input wire [7:0] timer_io_pin_oe_o,
  input wire [63:0] subsystem_counter_o,
  input wire [63:0] period_compare_register_o,
  input wire [15:0] match_flag_o,
  input wire [3:0] irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // low byte of subsystem 0 and its enabled flags
  wire [7:0] lo_w = subsystem_counter_o[7:0];
  wire [3:0] req_w = match_flag_o[3:0] & irq_en_i[3:0];
  reg wr_d1_q; // counter write strobe one cycle back
  reg wr_d2_q; // counter write strobe two cycles back
  // delayed copies of the strobe, so a preset jump is not taken for a skipped count
  always @(posedge clk_i) begin
    wr_d1_q <= cnt_wr_i[0];
    wr_d2_q <= wr_d1_q;
  end
  wire no_wr_w = !cnt_wr_i[0] && !wr_d1_q && !wr_d2_q;
  // lane 0 stopped with a steady default level
  sequence s_stop0;
    (!counter_go_bit_i[0] && $stable(output_default_level_bit_i[0])) [*3];
  endsequence
  // subsystem 0 held in low power, out of reset
  sequence s_lp0;
    (low_power_i[0] && !sys_rst_i) [*3];
  endsequence
  // one period write followed by two quiet cycles
  sequence s_wr0;
    (per_wr_i[0] && !low_power_i[0]) ##1 !per_wr_i[0] [*2];
  endsequence
  a_oe_driven: assert property ($past(!sys_rst_i) |-> timer_io_pin_oe_o == 8'hff)
    else $error("pins not driven");
  a_stop_level: assert property (s_stop0 |-> timer_io_pin_o[0] == output_default_level_bit_i[0])
    else $error("stopped pin off default");
  a_cnt_step: assert property ($changed(lo_w) && no_wr_w |-> lo_w == $past(lo_w) + 8'h01 || lo_w == 8'h00)
    else $error("counter skipped");
  a_ps_gap: assert property ($changed(lo_w) && prescale_match_field_i[7:0] != 8'h00 && no_wr_w |=> $stable(lo_w))
    else $error("prescaler too fast");
  a_lp_hold: assert property (s_lp0 |-> $stable(subsystem_counter_o[15:0]) && ($past(match_flag_o[3:0]) & ~match_flag_o[3:0]) == 4'h0)
    else $error("low power not frozen");
  a_flag_clear: assert property ($past(!sys_rst_i) && $fell(match_flag_o[0]) |-> $past(flag_clr_i[0]) || $past(flag_clr_i[0], 2))
    else $error("flag fell unasked");
  a_irq_on: assert property ((req_w != 4'h0) [*3] |-> irq_o[0])
    else $error("request missing");
  a_irq_off: assert property ((req_w == 4'h0) [*3] |-> !irq_o[0])
    else $error("request spurious");
  a_cmp_read: assert property (s_wr0 |-> period_compare_register_o[15:0] == $past(cmp_wdata_i[15:0], 2))
    else $error("period readback wrong");
endmodule
bind mctu_top mctu_assertions i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .low_power_i(low_power_i),
  .counter_go_bit_i(counter_go_bit_i), .output_default_level_bit_i(output_default_level_bit_i),
  .prescale_match_field_i(prescale_match_field_i), .cnt_wr_i(cnt_wr_i), .per_wr_i(per_wr_i),
  .cmp_wdata_i(cmp_wdata_i), .irq_en_i(irq_en_i), .flag_clr_i(flag_clr_i), .timer_io_pin_o(timer_io_pin_o),
  .timer_io_pin_oe_o(timer_io_pin_oe_o), .subsystem_counter_o(subsystem_counter_o),
  .period_compare_register_o(period_compare_register_o), .match_flag_o(match_flag_o), .irq_o(irq_o));

//--- dv/test_mctu_top.sv
// self-checking bench for the timer unit
`timescale 1ns/10ps
module test_mctu_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg ce = 1'b1;
  reg [3:0] lp = 4'h0, wide = 4'h0, cwr = 4'h0, pwr = 4'h0, dwr = 4'h0;
  reg [7:0] go = 8'h00, dflt = 8'h04;
  reg [31:0] ps = 32'h0000_0001;
  reg [63:0] cdat = 64'h0, wdat = 64'h0;
  reg [15:0] en = 16'h000f, clr = 16'h0000;
  wire [7:0] pin, oe, pin_in, lvl;
  wire [63:0] cnt, per, duty;
  wire [15:0] flg;
  wire [3:0] irq;
  integer n_mismatch = 0;
  integer n_checks = 0;
  integer h, p, i;
  mctu_top i_dut (.clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .low_power_i(lp), .wide_mode_i(wide),
    .counter_go_bit_i(go), .output_default_level_bit_i(dflt), .prescale_match_field_i(ps), .cnt_wr_i(cwr),
    .cnt_wdata_i(cdat), .per_wr_i(pwr), .duty_wr_i(dwr), .cmp_wdata_i(wdat), .irq_en_i(en), .flag_clr_i(clr),
    .timer_io_pin_i(lvl), .timer_io_pin_o(pin), .timer_io_pin_oe_o(oe), .subsystem_counter_o(cnt),
    .period_compare_register_o(per), .duty_compare_register_o(duty), .match_flag_o(flg), .irq_o(irq),
    .pin_in_o(pin_in));
  mctu_pin_load i_load (.pin_o_i(pin), .pin_oe_i(oe), .pin_level_o(lvl));
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task check(input [63:0] seen, input [63:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // inputs move one nanosecond after the edge, away from sampling
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // period then duty write, one strobe each on the shared data bus
  task wcmp(input integer s, input [15:0] pv, input [15:0] dv);
    wdat[16*s +: 16] = pv;
    pwr[s] = 1'b1;
    tick(1);
    pwr[s] = 1'b0;
    wdat[16*s +: 16] = dv;
    dwr[s] = 1'b1;
    tick(1);
    dwr[s] = 1'b0;
  endtask
  // bounded count of cycles a pin stays at one level
  task hold(input integer k, input v, output integer n);
    n = 0;
    while (pin[k] === v && n < 3000) begin
      n = n + 1;
      tick(1);
    end
    if (n == 3000) begin
      n_mismatch = n_mismatch + 1;
      complete_run;
    end
  endtask
  // partial waves are skipped so h and p cover one whole period
  task measure(input integer k);
    hold(k, 1'b1, h);
    hold(k, 1'b0, p);
    hold(k, 1'b1, h);
    hold(k, 1'b0, p);
    p = p + h;
  endtask
  // lane 0 normal, lane 1 duty above period, lane 2 zero duty
  task t_dual;
    wcmp(0, 16'h0203, 16'h0301);
    wcmp(1, 16'h0003, 16'h0000);
    go = 8'h07;
    tick(20);
    measure(0);
    check(h, 2);
    check(p, 8);
    check(pin[2:1], 2'b11);
    check(flg[3:0], 4'hb);
    check(irq[0], 1'b1);
    check(per[15:0], 16'h0203);
    check(duty[15:0], 16'h0301);
  endtask
  // compare update while running, then a refused counter write
  task t_buffer;
    wcmp(0, 16'h0205, 16'h0301);
    check(per[15:0], 16'h0205);
    measure(0);
    check(p, 12);
    cdat[15:0] = 16'h00f0;
    cwr[0] = 1'b1;
    tick(1);
    cwr[0] = 1'b0;
    tick(3);
    check(cnt[7:0] > 8'h05, 1'b0);
  endtask
  // stop lane 0, freeze in low power, then clear flags
  task t_stop;
    go[0] = 1'b0;
    tick(4);
    check(pin[0], dflt[0]);
    h = cnt[7:0];
    tick(6);
    check(cnt[7:0], h);
    check(pin_in, pin);
    lp[0] = 1'b1;
    clr = 16'h000f;
    tick(1);
    clr = 16'h0000;
    tick(3);
    check(flg[1:0], 2'b11);
    lp[0] = 1'b0;
    go[1] = 1'b0;
    tick(3);
    clr = 16'h000f;
    tick(1);
    clr = 16'h0000;
    tick(3);
    check(flg[3:0], 4'h0);
  endtask
  // preset above the period rolls through ff
  task t_preset;
    cdat[15:0] = 16'h00fe;
    cwr[0] = 1'b1;
    tick(1);
    cwr[0] = 1'b0;
    tick(3);
    check(cnt[7:0], 8'hfe);
    go[0] = 1'b1;
    h = 0;
    for (i = 0; i < 40; i = i + 1) begin
      if (cnt[7:0] === 8'hff) h = 1;
      if (cnt[7:0] === 8'hff) check(pin[0], dflt[0]);
      tick(1);
    end
    check(h, 1);
  endtask
  // subsystem 2 as one wide channel, pins of opposite default
  task t_wide;
    wide[2] = 1'b1;
    ps[23:16] = 8'h00;
    dflt = 8'h24;
    wcmp(2, 16'h0100, 16'h0080);
    go[4] = 1'b1;
    measure(4);
    check(h, 128);
    check(p, 257);
    repeat (300) begin
      check(pin[5] ^ pin[4], 1'b1);
      tick(1);
    end
    // clock enable low must hold the running wide counter
    ce = 1'b0;
    tick(1);
    h = cnt[47:32];
    tick(5);
    check(cnt[47:32], h);
    ce = 1'b1;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    tick(20);
    rst = 1'b0;
    tick(2);
    check(oe, 8'hff);
    check(cnt, 64'h0);
    t_dual;
    t_buffer;
    t_stop;
    t_preset;
    t_wide;
    complete_run;
  end
endmodule
